/* File: tmr_pkg.sv */
package tmr_pkg;
   // time-base dividers, in system clocks
   localparam int SLOW_DIV = 12;
   localparam int FAST_DIV = 4;
   // clock-out mode counts every second clock, giving osc/(4*span)
   localparam int CLKOUT_DIV = 2;
   // timer mode register fields
   localparam int MODE0_LSB = 0;
   localparam int CT0_BIT = 2;
   localparam int GATE0_BIT = 3;
   localparam int MODE1_LSB = 4;
   localparam int CT1_BIT = 6;
   localparam int GATE1_BIT = 7;
   // clock control register fields
   localparam int T0_FAST_BIT = 3;
   localparam int T1_FAST_BIT = 4;
   localparam logic [7:0] CLK_CTL_RST = 8'h00;
   // timer 0/1 modes
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_RELOAD8 = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   // count limits
   localparam logic [4:0] LOW5_MAX = 5'h1F;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   // sampled pin indices
   localparam int PIN_T0 = 0;
   localparam int PIN_T1 = 1;
   localparam int PIN_T2 = 2;
   localparam int PIN_TRIG = 3;
   localparam int N_PINS = 4;
endpackage : tmr_pkg

/* File: tmr_base.sv */
`timescale 1ns/10ps
module tmr_base
   import tmr_pkg::*;
#(
   parameter int NPIN = N_PINS,
   parameter int SDIV = SLOW_DIV,
   parameter int FDIV = FAST_DIV
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // pins
   input wire logic [NPIN-1:0] pins_i,
   // ticks and edges
   output logic tick_slow_o,
   output logic tick_fast_o,
   output logic tick_half_o,
   output logic [NPIN-1:0] pin_fall_o
);
   if (SDIV < 2 || SDIV > 255 || FDIV < 2 || FDIV > 255) begin : g_chk
      $error("tmr_base: divider out of range");
   end

   logic [7:0] slow_reg;
   logic [7:0] fast_reg;
   logic half_reg;
   logic [NPIN-1:0] samp_reg;
   logic [NPIN-1:0] prev_reg;

   assign tick_slow_o = (slow_reg == 8'(SDIV - 1));
   assign tick_fast_o = (fast_reg == 8'(FDIV - 1));
   assign tick_half_o = half_reg;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         slow_reg <= 8'h00;
         fast_reg <= 8'h00;
         half_reg <= 1'b0;
      end else begin
         slow_reg <= tick_slow_o ? 8'h00 : slow_reg + 8'h01;
         fast_reg <= tick_fast_o ? 8'h00 : fast_reg + 8'h01;
         half_reg <= ~half_reg;
      end
   end

   // one sample per machine cycle; a pulse narrower than that may be missed
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            samp_reg[i] <= 1'b0;
            prev_reg[i] <= 1'b0;
         end else if (tick_fast_o) begin
            samp_reg[i] <= pins_i[i];
            prev_reg[i] <= samp_reg[i];
         end
      end
      assign pin_fall_o[i] = tick_fast_o & prev_reg[i] & ~samp_reg[i];
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_slow_period;
      tick_slow_o |=> !tick_slow_o [*8] ##1 !tick_slow_o [*3] ##1 tick_slow_o;
   endproperty
   a_slow_period: assert property (p_slow_period) else $error("slow tick period wrong");
   property p_fast_period;
      tick_fast_o |=> !tick_fast_o [*3] ##1 tick_fast_o;
   endproperty
   a_fast_period: assert property (p_fast_period) else $error("fast tick period wrong");
endmodule : tmr_base

/* File: tmr_counters.sv */
// Function
// - timers 0/1 count at clock/12 when fast-base bit clear, clock/4 when set.
// - reset clears both fast-base bits, giving the clock/12 rate.
// - mode 0 counter is high byte plus low five bits of low byte.
// - mode 0 low-bit-4 fall bumps high byte; 1FFFh wraps to 0, sets flag.
// - timers 0/1 advance only when running (timer 1 needs no run bit in timer 0 mode 3) and gate off or gate pin high.
// - select clear counts time-base; select set counts count-pin falling edges.
// - mode 1 is a full 16-bit counter; FFFFh wrap sets overflow flag.
// - mode 2 low byte overflow sets flag, reloads from unchanged high byte.
// - timer 1 in mode 3 holds its count.
// - timer 0 mode 3: low byte is 8-bit counter with timer 0 controls.
// - timer 0 mode 3: high byte counts time-base, timer 1 run, timer 1 flag.
// - then timer 1 runs without run bit or flag, stopped by its mode 3.
// - timer 2 counts its pin or clock/12 or /4 (clock/2 in clock-out mode), only while running.
// - capture mode counts up 16 bits; wrap sets flag, requests interrupt.
// - enabled trigger fall captures count, sets external flag and interrupt.
// - capture-clear bit zeroes timer 2 right after each capture.
// - up auto-reload reloads from capture bytes on wrap or enabled trigger.
// - up/down: trigger pin sets direction; reloads from capture or FFFFh.
// - up/down mode reload toggles external flag, which raises no interrupt.
// - baud modes auto-reload without overflow flag; trigger sets external flag.
// - clock-out mode drives a 50% clock while running, no overflow interrupt.
// - clock-out frequency is oscillator over four times the reload span.
// - count pins sampled once per machine cycle; high then low is an edge.
// - mode register bit 2 selects timer 0 source, bit 6 timer 1.
`timescale 1ns/10ps
module tmr_counters
   import tmr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // processor byte writes
   input wire logic [7:0] wdata_i,
   input wire logic wr_clock_control_i,
   input wire logic wr_timer0_low_i,
   input wire logic wr_timer0_high_i,
   input wire logic wr_timer1_low_i,
   input wire logic wr_timer1_high_i,
   input wire logic wr_timer2_low_i,
   input wire logic wr_timer2_high_i,
   input wire logic wr_capture_low_i,
   input wire logic wr_capture_high_i,
   // timer 0/1 control
   input wire logic [7:0] timer_mode_reg_i,
   input wire logic timer0_run_bit_i,
   input wire logic timer1_run_bit_i,
   input wire logic timer0_overflow_clr_i,
   input wire logic timer1_overflow_clr_i,
   // timer 2 control
   input wire logic timer2_run_bit_i,
   input wire logic timer2_source_sel_i,
   input wire logic timer2_fast_base_sel_i,
   input wire logic capture_reload_sel_i,
   input wire logic trigger_enable_bit_i,
   input wire logic rx_baud_clock_sel_i,
   input wire logic tx_baud_clock_sel_i,
   input wire logic down_count_enable_i,
   input wire logic capture_clear_bit_i,
   input wire logic clock_out_enable_i,
   input wire logic timer2_overflow_clr_i,
   input wire logic external_event_clr_i,
   // pins
   input wire logic timer0_gate_pin_i,
   input wire logic timer1_gate_pin_i,
   input wire logic timer0_count_pin_i,
   input wire logic timer1_count_pin_i,
   input wire logic timer2_clock_pin_i,
   input wire logic timer2_trigger_pin_i,
   // state readback
   output logic [7:0] clock_control_reg_o,
   output logic [7:0] timer0_low_byte_o,
   output logic [7:0] timer0_high_byte_o,
   output logic [7:0] timer1_low_byte_o,
   output logic [7:0] timer1_high_byte_o,
   output logic [7:0] timer2_low_byte_o,
   output logic [7:0] timer2_high_byte_o,
   output logic [7:0] capture_low_byte_o,
   output logic [7:0] capture_high_byte_o,
   // flags and requests
   output logic timer0_overflow_flag_o,
   output logic timer1_overflow_flag_o,
   output logic timer2_overflow_flag_o,
   output logic external_event_flag_o,
   output logic timer2_irq_o,
   output logic timer2_reload_o,
   // clock-out pin
   output logic clock_out_o,
   output logic clock_out_oe_o
);
   logic tick_slow;
   logic tick_fast;
   logic tick_half;
   logic [N_PINS-1:0] fall;
   logic [7:0] clk_ctl_reg;
   logic [7:0] tl0_reg, th0_reg, tl1_reg, th1_reg;
   logic [15:0] t2_reg, cap_reg;
   logic tf0_reg, tf1_reg, tf2_reg, external_event_flag_reg, clkout_reg;

   tmr_base #(.NPIN(N_PINS), .SDIV(SLOW_DIV), .FDIV(FAST_DIV)) u_base (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .pins_i({timer2_trigger_pin_i, timer2_clock_pin_i, timer1_count_pin_i, timer0_count_pin_i}),
      .tick_slow_o(tick_slow),
      .tick_fast_o(tick_fast),
      .tick_half_o(tick_half),
      .pin_fall_o(fall)
   );

   // step of a timer 0/1 pair in modes 0..2; bit 16 is the overflow
   function automatic logic [16:0] step01(input logic [1:0] m, input logic [7:0] hi,
                                          input logic [7:0] lo);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      case (m)
         MODE_13BIT: begin
            r[4:0] = lo[4:0] + 5'h01;
            if (lo[4:0] == LOW5_MAX) begin
               r[15:8] = hi + 8'h01;
               r[16] = (hi == BYTE_MAX);
            end
         end
         MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
         MODE_RELOAD8: begin
            if (lo == BYTE_MAX) begin
               r[7:0] = hi;
               r[16] = 1'b1;
            end else begin
               r[7:0] = lo + 8'h01;
            end
         end
         default: r = {1'b0, hi, lo};
      endcase
      return r;
   endfunction : step01

   // clock control: only the fast-base bits steer the timers here
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         clk_ctl_reg <= CLK_CTL_RST;
      end else if (wr_clock_control_i) begin
         clk_ctl_reg <= wdata_i;
      end
   end

   logic [1:0] mode0, mode1;
   logic split, base0, base1, ok0, ok1, inc0, inc1, th0_inc;
   logic [16:0] nx0, nx1;
   assign mode0 = timer_mode_reg_i[MODE0_LSB +: 2];
   assign mode1 = timer_mode_reg_i[MODE1_LSB +: 2];
   assign split = (mode0 == MODE_SPLIT);
   assign base0 = clk_ctl_reg[T0_FAST_BIT] ? tick_fast : tick_slow;
   assign base1 = clk_ctl_reg[T1_FAST_BIT] ? tick_fast : tick_slow;
   assign ok0 = timer0_run_bit_i & (~timer_mode_reg_i[GATE0_BIT] | timer0_gate_pin_i);
   // in split mode timer 1 loses its run bit; only its own mode 3 or its gate stops it
   assign ok1 = (split | timer1_run_bit_i) &
                (~timer_mode_reg_i[GATE1_BIT] | timer1_gate_pin_i);
   assign inc0 = ok0 & (timer_mode_reg_i[CT0_BIT] ? fall[PIN_T0] : base0);
   assign inc1 = ok1 & (mode1 != MODE_SPLIT) &
                 (timer_mode_reg_i[CT1_BIT] ? fall[PIN_T1] : base1);
   assign th0_inc = split & timer1_run_bit_i & base0;
   assign nx0 = step01(mode0, th0_reg, tl0_reg);
   assign nx1 = step01(mode1, th1_reg, tl1_reg);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tl0_reg <= 8'h00;
         th0_reg <= 8'h00;
      end else begin
         if (wr_timer0_low_i) begin
            tl0_reg <= wdata_i;
         end else if (inc0) begin
            tl0_reg <= split ? tl0_reg + 8'h01 : nx0[7:0];
         end
         if (wr_timer0_high_i) begin
            th0_reg <= wdata_i;
         end else if (split) begin
            if (th0_inc) begin
               th0_reg <= th0_reg + 8'h01;
            end
         end else if (inc0) begin
            th0_reg <= nx0[15:8];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tl1_reg <= 8'h00;
         th1_reg <= 8'h00;
      end else begin
         if (wr_timer1_low_i) begin
            tl1_reg <= wdata_i;
         end else if (inc1) begin
            tl1_reg <= nx1[7:0];
         end
         if (wr_timer1_high_i) begin
            th1_reg <= wdata_i;
         end else if (inc1) begin
            th1_reg <= nx1[15:8];
         end
      end
   end

   logic set_tf0, set_tf1;
   assign set_tf0 = inc0 & (split ? (tl0_reg == BYTE_MAX) : nx0[16]);
   assign set_tf1 = split ? (th0_inc & (th0_reg == BYTE_MAX)) : (inc1 & nx1[16]);

   // a set in the cycle of a clear wins
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tf0_reg <= 1'b0;
         tf1_reg <= 1'b0;
      end else begin
         tf0_reg <= set_tf0 | (tf0_reg & ~timer0_overflow_clr_i);
         tf1_reg <= set_tf1 | (tf1_reg & ~timer1_overflow_clr_i);
      end
   end

   // timer 2
   logic baud, capm, updn, clkm, t2_tick, trig, t2_wrap, t2_dn_hit, go_down;
   assign baud = rx_baud_clock_sel_i | tx_baud_clock_sel_i;
   assign capm = capture_reload_sel_i & ~baud;
   assign updn = ~capture_reload_sel_i & ~baud & down_count_enable_i;
   assign clkm = clock_out_enable_i & ~timer2_source_sel_i & ~capture_reload_sel_i;
   assign t2_tick = timer2_run_bit_i & (timer2_source_sel_i ? fall[PIN_T2] :
                    clkm ? tick_half :
                    timer2_fast_base_sel_i ? tick_fast : tick_slow);
   assign trig = trigger_enable_bit_i & fall[PIN_TRIG] & ~updn;
   assign go_down = updn & ~timer2_trigger_pin_i;
   assign t2_wrap = t2_tick & ~go_down & (t2_reg == WORD_MAX);
   assign t2_dn_hit = t2_tick & go_down & (t2_reg == cap_reg);
   assign timer2_reload_o = (t2_wrap & ~capm) | t2_dn_hit;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         t2_reg <= WORD_ZERO;
      end else if (wr_timer2_low_i) begin
         t2_reg[7:0] <= wdata_i;
      end else if (wr_timer2_high_i) begin
         t2_reg[15:8] <= wdata_i;
      end else if (trig & capm) begin
         if (capture_clear_bit_i) begin
            t2_reg <= WORD_ZERO;
         end else if (t2_tick) begin
            t2_reg <= t2_reg + 16'h0001;
         end
      end else if (trig & ~baud) begin
         t2_reg <= cap_reg;
      end else if (t2_dn_hit) begin
         t2_reg <= WORD_MAX;
      end else if (t2_wrap & ~capm) begin
         t2_reg <= cap_reg;
      end else if (t2_tick) begin
         t2_reg <= go_down ? t2_reg - 16'h0001 : t2_reg + 16'h0001;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cap_reg <= WORD_ZERO;
      end else if (wr_capture_low_i) begin
         cap_reg[7:0] <= wdata_i;
      end else if (wr_capture_high_i) begin
         cap_reg[15:8] <= wdata_i;
      end else if (trig & capm) begin
         cap_reg <= t2_reg;
      end
   end

   logic set_tf2, set_external_event_flag, tgl_external_event_flag;
   assign set_tf2 = (t2_wrap & ~baud & ~clkm) | t2_dn_hit;
   assign set_external_event_flag = trig;
   assign tgl_external_event_flag = updn & timer2_reload_o;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tf2_reg <= 1'b0;
         external_event_flag_reg <= 1'b0;
      end else begin
         tf2_reg <= set_tf2 | (tf2_reg & ~timer2_overflow_clr_i);
         if (tgl_external_event_flag) begin
            external_event_flag_reg <= ~external_event_flag_reg;
         end else begin
            external_event_flag_reg <= set_external_event_flag | (external_event_flag_reg & ~external_event_clr_i);
         end
      end
   end

   // toggling on each reload gives a 50% clock of osc/(4*(10000h-reload))
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         clkout_reg <= 1'b0;
      end else if (clkm & t2_wrap) begin
         clkout_reg <= ~clkout_reg;
      end
   end

   assign clock_control_reg_o = clk_ctl_reg;
   assign timer0_low_byte_o = tl0_reg;
   assign timer0_high_byte_o = th0_reg;
   assign timer1_low_byte_o = tl1_reg;
   assign timer1_high_byte_o = th1_reg;
   assign timer2_low_byte_o = t2_reg[7:0];
   assign timer2_high_byte_o = t2_reg[15:8];
   assign capture_low_byte_o = cap_reg[7:0];
   assign capture_high_byte_o = cap_reg[15:8];
   assign timer0_overflow_flag_o = tf0_reg;
   assign timer1_overflow_flag_o = tf1_reg;
   assign timer2_overflow_flag_o = tf2_reg;
   assign external_event_flag_o = external_event_flag_reg;
   assign timer2_irq_o = tf2_reg | (external_event_flag_reg & ~updn);
   assign clock_out_o = clkout_reg;
   assign clock_out_oe_o = clkm;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_m0_wrap;
      (mode0 == MODE_13BIT) && inc0 && ({th0_reg, tl0_reg[4:0]} == 13'h1FFF) &&
      !wr_timer0_low_i && !wr_timer0_high_i |=> tf0_reg && th0_reg == 8'h00 &&
      tl0_reg[4:0] == 5'h00;
   endproperty
   a_m0_wrap: assert property (p_m0_wrap) else $error("mode 0 wrap wrong");
   property p_m1_wrap;
      (mode1 == MODE_16BIT) && !split && inc1 && th1_reg == 8'hFF && tl1_reg == 8'hFF
      && !wr_timer1_low_i && !wr_timer1_high_i |=> tf1_reg && {th1_reg, tl1_reg} == 16'h0000;
   endproperty
   a_m1_wrap: assert property (p_m1_wrap) else $error("mode 1 wrap wrong");
   property p_m2_reload;
      (mode0 == MODE_RELOAD8) && inc0 && tl0_reg == 8'hFF && !wr_timer0_low_i &&
      !wr_timer0_high_i |=> tl0_reg == $past(th0_reg) && th0_reg == $past(th0_reg) && tf0_reg;
   endproperty
   a_m2_reload: assert property (p_m2_reload) else $error("mode 2 reload wrong");
   property p_t1_freeze;
      (mode1 == MODE_SPLIT) && !wr_timer1_low_i && !wr_timer1_high_i |=>
      $stable(tl1_reg) && $stable(th1_reg);
   endproperty
   a_t1_freeze: assert property (p_t1_freeze) else $error("timer 1 not frozen");
   property p_t0_stop;
      !timer0_run_bit_i && !split && !wr_timer0_low_i && !wr_timer0_high_i |=>
      $stable(tl0_reg) && $stable(th0_reg);
   endproperty
   a_t0_stop: assert property (p_t0_stop) else $error("timer 0 ran while stopped");
   property p_split_hi;
      split && !timer1_run_bit_i && !wr_timer0_high_i |=> $stable(th0_reg);
   endproperty
   a_split_hi: assert property (p_split_hi) else $error("split high byte ran");
   property p_rst_slow;
      $rose(rstn_i) |-> clk_ctl_reg == 8'h00 [*2];
   endproperty
   a_rst_slow: assert property (p_rst_slow) else $error("fast base set after reset");
   property p_cap_wrap;
      capm && t2_tick && t2_reg == 16'hFFFF && !trig && !wr_timer2_low_i &&
      !wr_timer2_high_i |=> t2_reg == 16'h0000 && tf2_reg && timer2_irq_o;
   endproperty
   a_cap_wrap: assert property (p_cap_wrap) else $error("capture wrap wrong");
   property p_capture;
      capm && trig && !wr_capture_low_i && !wr_capture_high_i |=>
      cap_reg == $past(t2_reg) && external_event_flag_reg && timer2_irq_o;
   endproperty
   a_capture: assert property (p_capture) else $error("capture wrong");
   property p_cap_clear;
      capm && trig && capture_clear_bit_i && !wr_timer2_low_i && !wr_timer2_high_i
      |=> t2_reg == 16'h0000;
   endproperty
   a_cap_clear: assert property (p_cap_clear) else $error("no clear after capture");
   property p_down_hit;
      t2_dn_hit && !wr_timer2_low_i && !wr_timer2_high_i |=>
      t2_reg == 16'hFFFF && tf2_reg && external_event_flag_reg != $past(external_event_flag_reg);
   endproperty
   a_down_hit: assert property (p_down_hit) else $error("down reload wrong");
   property p_baud_noflag;
      baud && !tf2_reg && !t2_dn_hit |=> !tf2_reg;
   endproperty
   a_baud_noflag: assert property (p_baud_noflag) else $error("baud set overflow flag");

   c_split_tf1: cover property (split && set_tf1);
   c_clkout: cover property (clkm && $rose(clkout_reg));
   c_updn_reload: cover property (updn && timer2_reload_o);
endmodule : tmr_counters

/* File: tmr_pins.sv */
`timescale 1ns/10ps
module tmr_pins (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // pulse requests per pin
   input wire logic [3:0] fire_i,
   // count, clock and trigger pins, idle high
   output logic [3:0] pin_o
);
   logic [4:0] cnt_reg [4];
   // 8 clocks per level, twice the sampling period
   always_ff @(posedge clk_i or negedge rstn_i) begin
      for (int k = 0; k < 4; k++) begin
         if (!rstn_i) cnt_reg[k] <= 5'h00;
         else if (cnt_reg[k] != 5'h00) cnt_reg[k] <= cnt_reg[k] - 5'h01;
         else if (fire_i[k]) cnt_reg[k] <= 5'h10;
      end
   end
   always_comb begin
      for (int k = 0; k < 4; k++) pin_o[k] = (cnt_reg[k] <= 5'h08);
   end
endmodule : tmr_pins

/* File: tmr_counters_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tmr_counters_bench;
   import tmr_pkg::*;
   typedef struct packed {logic [7:0] tm, ck, hi, lo, ehi, elo; logic t1; logic [3:0] n;} tmr_row_t;
   logic clk_i = 1'h0, rstn_i = 1'h0;
   logic [7:0] wdata_i = 8'h00, timer_mode_reg_i = 8'h00;
   logic [8:0] wr = 9'h000;
   logic [3:0] clr = 4'h0, fire = 4'h0;
   logic timer0_run_bit_i = 1'h0, timer1_run_bit_i = 1'h0, timer2_run_bit_i = 1'h0;
   logic timer0_gate_pin_i = 1'h1, timer1_gate_pin_i = 1'h1, timer2_source_sel_i = 1'h0;
   logic timer2_fast_base_sel_i = 1'h0, capture_reload_sel_i = 1'h0, rx_baud_clock_sel_i = 1'h0;
   logic trigger_enable_bit_i = 1'h0, tx_baud_clock_sel_i = 1'h0, down_count_enable_i = 1'h0;
   logic capture_clear_bit_i = 1'h0, clock_out_enable_i = 1'h0;
   wire logic wr_clock_control_i, wr_timer0_low_i, wr_timer0_high_i, wr_timer1_low_i;
   wire logic wr_timer1_high_i, wr_timer2_low_i, wr_timer2_high_i, wr_capture_low_i;
   wire logic wr_capture_high_i, timer0_overflow_clr_i, timer1_overflow_clr_i;
   wire logic timer2_overflow_clr_i, external_event_clr_i, timer0_count_pin_i;
   wire logic timer1_count_pin_i, timer2_clock_pin_i, timer2_trigger_pin_i;
   logic [7:0] clock_control_reg_o, timer0_low_byte_o, timer0_high_byte_o, timer1_low_byte_o;
   logic [7:0] timer1_high_byte_o, timer2_low_byte_o, timer2_high_byte_o;
   logic [7:0] capture_low_byte_o, capture_high_byte_o;
   logic timer0_overflow_flag_o, timer1_overflow_flag_o, timer2_overflow_flag_o;
   logic external_event_flag_o, timer2_irq_o, timer2_reload_o, clock_out_o, clock_out_oe_o;
   wire logic [3:0] flags = {external_event_flag_o, timer2_overflow_flag_o,
      timer1_overflow_flag_o, timer0_overflow_flag_o};
   int n_fail = 0;
   int n_checks = 0;
   int cyc, div;
   tmr_row_t r;
   // mode, base, preload, bytes right after the wrap, ticks needed
   tmr_row_t rows [5] = '{
      '{8'h00, 8'h00, 8'hFF, 8'hFE, 8'h00, 8'hE0, 1'h0, 4'h2},
      '{8'h01, 8'h08, 8'hFF, 8'hFD, 8'h00, 8'h00, 1'h0, 4'h3},
      '{8'h20, 8'h00, 8'hA5, 8'hFE, 8'hA5, 8'hA5, 1'h1, 4'h2},
      '{8'h10, 8'h10, 8'hFF, 8'hFF, 8'h00, 8'h00, 1'h1, 4'h1},
      '{8'h03, 8'h08, 8'h00, 8'hFF, 8'h00, 8'h00, 1'h0, 4'h1}};
   assign {wr_capture_high_i, wr_capture_low_i, wr_timer2_high_i, wr_timer2_low_i,
      wr_timer1_high_i, wr_timer1_low_i, wr_timer0_high_i, wr_timer0_low_i,
      wr_clock_control_i} = wr;
   assign {external_event_clr_i, timer2_overflow_clr_i, timer1_overflow_clr_i,
      timer0_overflow_clr_i} = clr;
   always #25 clk_i = ~clk_i;
   tmr_counters tmr_counters_i (.*);
   tmr_pins tmr_pins_i (.clk_i(clk_i), .rstn_i(rstn_i), .fire_i(fire),
      .pin_o({timer2_trigger_pin_i, timer2_clock_pin_i, timer1_count_pin_i, timer0_count_pin_i}));
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   // a spare cycle after every strobe keeps writes from merging
   task wr_b(input int s, input logic [7:0] d);
      @(negedge clk_i);
      wdata_i = d;
      wr = 9'h001 << s;
      @(negedge clk_i);
      wr = 9'h000;
   endtask : wr_b
   task load(input int s, input logic [7:0] h, l);
      wr_b(s + 1, h);
      wr_b(s, l);
   endtask : load
   task clr_flags;
      @(negedge clk_i);
      clr = 4'hF;
      @(negedge clk_i);
      clr = 4'h0;
   endtask : clr_flags
   task pulse(input int k);
      fire[k] = 1'h1;
      @(negedge clk_i);
      fire[k] = 1'h0;
      repeat (20) @(negedge clk_i);
   endtask : pulse
   // stops all runs as soon as the flag shows, before another tick lands
   task wait_flag(input int f);
      cyc = 0;
      while (flags[f] !== 1'h1 && cyc < 3000) begin
         @(negedge clk_i);
         cyc++;
      end
      {timer0_run_bit_i, timer1_run_bit_i, timer2_run_bit_i} = 3'h0;
      `CHK("flag", 1'h1, flags[f])
   endtask : wait_flag
   initial begin
      repeat (40000) @(posedge clk_i);
      n_fail++;
      $display("watchdog expired");
      finish_test;
   end
   initial begin
      repeat (20) @(negedge clk_i);
      rstn_i = 1'h1;
      `CHK("clkctl", CLK_CTL_RST, clock_control_reg_o)
      `CHK("flags", 4'h0, flags)
      $display("test reset done");
      foreach (rows[i]) begin
         r = rows[i];
         timer_mode_reg_i = r.tm;
         wr_b(0, r.ck);
         load(r.t1 ? 3 : 1, r.hi, r.lo);
         clr_flags;
         if (r.t1) timer1_run_bit_i = 1'h1;
         else timer0_run_bit_i = 1'h1;
         wait_flag(r.t1);
         div = (r.ck != 8'h00) ? FAST_DIV : SLOW_DIV;
         `CHK("span", 1'h1, 1'(cyc > (r.n - 1) * div && cyc <= r.n * div + 2))
         `CHK("hi", r.ehi, r.t1 ? timer1_high_byte_o : timer0_high_byte_o)
         `CHK("lo", r.elo, r.t1 ? timer1_low_byte_o : timer0_low_byte_o)
         repeat (20) @(negedge clk_i);
         `CHK("sticky", 1'h1, flags[r.t1])
         $display("test overflow row %0d done", i);
      end
      timer_mode_reg_i = 8'h09;
      timer0_gate_pin_i = 1'h0;
      load(1, 8'h00, 8'h00);
      timer0_run_bit_i = 1'h1;
      repeat (40) @(negedge clk_i);
      `CHK("gated", 8'h00, timer0_low_byte_o)
      timer0_gate_pin_i = 1'h1;
      repeat (40) @(negedge clk_i);
      `CHK("ungated", 1'h1, 1'(timer0_low_byte_o != 8'h00))
      timer0_run_bit_i = 1'h0;
      $display("test gate done");
      timer_mode_reg_i = 8'h50;
      load(3, 8'hFF, 8'hFE);
      clr_flags;
      timer1_run_bit_i = 1'h1;
      repeat (2) pulse(1);
      `CHK("pin", 8'h00, timer1_low_byte_o)
      wait_flag(1);
      timer_mode_reg_i = 8'h30;
      load(3, 8'h12, 8'h34);
      timer1_run_bit_i = 1'h1;
      repeat (60) @(negedge clk_i);
      `CHK("frozen", 8'h34, timer1_low_byte_o)
      timer_mode_reg_i = 8'h03;
      load(1, 8'hFF, 8'h00);
      clr_flags;
      timer1_run_bit_i = 1'h1;
      wait_flag(1);
      `CHK("split", 16'h0000, {timer0_high_byte_o, timer0_low_byte_o})
      $display("test pin, freeze and split done");
      timer2_fast_base_sel_i = 1'h1;
      capture_reload_sel_i = 1'h1;
      load(5, 8'hFF, 8'hFF);
      clr_flags;
      timer2_run_bit_i = 1'h1;
      wait_flag(2);
      `CHK("t2wrap", WORD_ZERO, {timer2_high_byte_o, timer2_low_byte_o})
      `CHK("irq", 1'h1, timer2_irq_o)
      // timer stopped, so the captured word is known
      trigger_enable_bit_i = 1'h1;
      load(5, 8'h9A, 8'hBC);
      clr_flags;
      capture_clear_bit_i = 1'h1;
      pulse(3);
      wait_flag(3);
      `CHK("capt", 16'h9ABC, {capture_high_byte_o, capture_low_byte_o})
      `CHK("cleared", WORD_ZERO, {timer2_high_byte_o, timer2_low_byte_o})
      capture_reload_sel_i = 1'h0;
      trigger_enable_bit_i = 1'h0;
      load(7, 8'h12, 8'h34);
      load(5, 8'hFF, 8'hFF);
      clr_flags;
      timer2_run_bit_i = 1'h1;
      wait_flag(2);
      `CHK("reload", 16'h1234, {timer2_high_byte_o, timer2_low_byte_o})
      tx_baud_clock_sel_i = 1'h1;
      clock_out_enable_i = 1'h1;
      load(5, 8'hFF, 8'hFE);
      clr_flags;
      timer2_run_bit_i = 1'h1;
      cyc = 0;
      while (timer2_reload_o !== 1'h1 && cyc < 200) begin
         @(negedge clk_i);
         cyc++;
      end
      `CHK("baud", 1'h1, timer2_reload_o)
      `CHK("oe", 1'h1, clock_out_oe_o)
      repeat (4) @(negedge clk_i);
      `CHK("noflag", 1'h0, timer2_overflow_flag_o)
      `CHK("clkout", 1'h1, clock_out_o)
      timer2_run_bit_i = 1'h0;
      // trigger pin idles high, so up/down mode counts up
      {tx_baud_clock_sel_i, clock_out_enable_i, down_count_enable_i} = 3'h1;
      load(5, 8'hFF, 8'hFF);
      clr_flags;
      timer2_run_bit_i = 1'h1;
      wait_flag(2);
      `CHK("updn", 16'h1234, {timer2_high_byte_o, timer2_low_byte_o})
      `CHK("toggle", 1'h1, external_event_flag_o)
      clr = 4'h4;
      @(negedge clk_i);
      clr = 4'h0;
      `CHK("noirq", 1'h0, timer2_irq_o)
      $display("test timer 2 done");
      // reset in mid-run must drop the fast-base bits written earlier
      rstn_i = 1'h0;
      @(negedge clk_i);
      `CHK("rst clkctl", CLK_CTL_RST, clock_control_reg_o)
      `CHK("rst flags", 4'h0, flags)
      rstn_i = 1'h1;
      $display("test reset again done");
      finish_test;
   end
endmodule : tmr_counters_bench
